/* File: eld_cfg.svh */
// Summary of operation
// - Busy set, ready cleared while loader runs
// - Byte 0 not A5h: sync PHYs, finish
// - Bytes 1-6 written to switch MAC registers
// - Strap flag A5h: bytes 8-11 into straps
// - Bad strap flag: read, discard four bytes
// - Always push current straps into PHY registers
// - Bytes 8,9 hold port 1,2 straps
// - Byte 10 port 0, byte 11 LEDs
// - Rewrite each port PHY advertise/modes/control whole
// - Port PHY control write sets restart autoneg
// - Return PHY management registers to defaults
// - Rewrite virtual PHY three registers whole
// - Virtual PHY control sets restart autoneg
// - Reload LED and three manual flowctl registers
// - Byte 12 not A5h: finish, clear busy
// - Byte 13 burst count, bursts address/count/data
// - First data byte is word bits 31:24
// - Byte address is DWORD address plus 00
// - Write only when CSR and PHY idle
// - EEPROM address past size limit: overflow, stop
// - After last burst: wait state, clear busy
// - Pin reset samples straps, then loader runs
// - Reload or digital reset also rewrites PHYs
`ifndef ELD_CFG_SVH
`define ELD_CFG_SVH
`define ELD_MAGIC       8'hA5
`define ELD_APB_CTRL    12'h000
`define ELD_APB_STATUS  12'h004
`define ELD_APB_STRAPS  12'h008
`define ELD_STRAP_RST   32'h0000_0000
`define ELD_LIMIT_0     16'h007F
`define ELD_LIMIT_1     16'h07FF
`define ELD_LIMIT_2     16'h3FFF
`define ELD_LIMIT_3     16'hFFFF
`define ELD_MAC_LO      10'h0A0
`define ELD_MAC_HI      10'h0A4
`define ELD_P1_ADV      10'h200
`define ELD_P1_MODES    10'h204
`define ELD_P1_BASIC    10'h208
`define ELD_P2_ADV      10'h210
`define ELD_P2_MODES    10'h214
`define ELD_P2_BASIC    10'h218
`define ELD_PHY_MGMT_ACCESS_REG  10'h0A8
`define ELD_PMI_DATA    10'h0AC
`define ELD_VP_ADV      10'h220
`define ELD_VP_SPECIAL  10'h224
`define ELD_VP_BASIC    10'h228
`define ELD_LED_CONFIG_REG     10'h1BC
`define ELD_MFC0        10'h1A0
`define ELD_MFC1        10'h1A4
`define ELD_MFC2        10'h1A8
`define ELD_SYNC_LAST   4'hE
`define ELD_B_RESTART   9
`define ELD_B_ANEN      12
`define ELD_B_SPEED     13
`define ELD_B_DUPLEX    8
`endif

/* File: eld_ee_model.sv */
`timescale 1ns/1ps
module eld_ee_model (
    // Clock and read port
    input  wire logic        clk_sys,
    input  wire logic        ee_rd_req,
    input  wire logic [15:0] ee_rd_addr,
    output logic             ee_rd_valid,
    output logic [7:0]       ee_rd_data
);
    logic [7:0] mem [0:255];
    int         seed = 5;
    int         dly  = 0;
    // Byte not held after the strobe, so a late sample sees garbage
    always @(posedge clk_sys) begin
        ee_rd_valid <= 1'b0;
        ee_rd_data  <= ~ee_rd_data;
        if (ee_rd_req && !ee_rd_valid) begin
            if (dly > 0)
                dly <= dly - 1;
            else begin
                ee_rd_valid <= 1'b1;
                ee_rd_data  <= mem[ee_rd_addr[7:0]];
                dly         <= {$random(seed)} % 4;
            end
        end
    end
endmodule

/* File: eld_loader.sv */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "eld_cfg.svh"
module eld_loader (
    // Clock, reset, enable
    input  wire logic               clk_sys,
    input  wire logic               srst,
    input  wire logic               clk_en,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Start events
    input  wire logic               strap_capture,
    input  wire logic               load_start,
    // Hardware straps
    input  wire logic [31:0]        hw_straps,
    input  wire logic [1:0]         eeprom_size_strap,
    // EEPROM controller read port
    output logic                    ee_rd_req,
    output logic [15:0]             ee_rd_addr,
    input  wire logic               ee_rd_valid,
    input  wire logic [7:0]         ee_rd_data,
    // System register write port
    output logic                    reg_wr_req,
    output eld_pkg::eld_wr_type     reg_wr,
    input  wire logic               reg_wr_ack,
    input  wire logic               switch_flag_a,
    input  wire logic               phy_mgmt_busy_flag,
    // Status
    output logic                    eeprom_ctrl_busy_flag,
    output logic                    device_ready,
    output logic                    loader_overflow,
    output logic [31:0]             strap_cfg
);
    import eld_pkg::*;

    eld_state_type state_q;
    eld_phase_type phase_q;
    eld_wkind_type wk_q;
    eld_wr_type    wr_q;
    logic [31:0]   straps_q;
    logic [47:0]   mac_q;
    logic [31:0]   word_q;
    logic [15:0]   ee_addr_q;
    logic [7:0]    nb_q;
    logic [7:0]    cnt_q;
    logic [7:0]    dw_addr_q;
    logic [3:0]    sync_idx_q;
    logic [2:0]    step_q;
    logic          busy_q;
    logic          ovf_q;
    logic          ee_ok_q;
    logic          sflag_ok_q;
    logic          reload_q;
    logic [31:0]   prdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] phy_adv(input logic spd, input logic dup,
                                            input logic fc);
        phy_adv = {21'h000000, fc, 1'b0, spd & dup, spd, dup, 1'b1, 5'h01};
    endfunction

    function automatic logic [31:0] phy_basic(input logic spd, input logic dup,
                                              input logic an);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[`ELD_B_SPEED]   = spd;
        v[`ELD_B_ANEN]    = an;
        v[`ELD_B_DUPLEX]  = dup;
        v[`ELD_B_RESTART] = 1'b1;
        phy_basic = v;
    endfunction

    // Strap-derived defaults, each register written whole
    function automatic eld_wr_type sync_item(input logic [3:0] idx, input logic [31:0] s);
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p0;
        logic [7:0] led;
        eld_wr_type w;
        p1  = s[7:0];
        p2  = s[15:8];
        p0  = s[23:16];
        led = s[31:24];
        w.addr = `ELD_PHY_MGMT_ACCESS_REG;
        w.data = 32'h0000_0000;
        unique case (idx)
            4'h0: w = '{`ELD_P1_ADV,   phy_adv(p1[2], p1[1], p1[6])};
            4'h1: w = '{`ELD_P1_MODES, {24'h000000, p1[2:0], 5'h00}};
            4'h2: w = '{`ELD_P1_BASIC, phy_basic(p1[2], p1[1], p1[0])};
            4'h3: w = '{`ELD_P2_ADV,   phy_adv(p2[2], p2[1], p2[6])};
            4'h4: w = '{`ELD_P2_MODES, {24'h000000, p2[2:0], 5'h00}};
            4'h5: w = '{`ELD_P2_BASIC, phy_basic(p2[2], p2[1], p2[0])};
            4'h6: w = '{`ELD_PHY_MGMT_ACCESS_REG, 32'h0000_0000};
            4'h7: w = '{`ELD_PMI_DATA,   32'h0000_0000};
            4'h8: w = '{`ELD_VP_ADV,     phy_adv(p0[2], 1'b1, p0[4])};
            4'h9: w = '{`ELD_VP_SPECIAL, {30'h00000000, p0[1:0]}};
            4'hA: w = '{`ELD_VP_BASIC,   phy_basic(p0[2], 1'b1, 1'b1)};
            4'hB: w = '{`ELD_LED_CONFIG_REG, {22'h000000, led[7:6], 2'h0, led[5:0]}};
            4'hC: w = '{`ELD_MFC0, {29'h00000000, p0[5:3]}};
            4'hD: w = '{`ELD_MFC1, {29'h00000000, p1[7:5]}};
            4'hE: w = '{`ELD_MFC2, {29'h00000000, p2[7:5]}};
            default: w = '{`ELD_PHY_MGMT_ACCESS_REG, 32'h0000_0000};
        endcase
        sync_item = w;
    endfunction

    function automatic logic [15:0] size_limit(input logic [1:0] sz);
        unique case (sz)
            2'd0: size_limit = `ELD_LIMIT_0;
            2'd1: size_limit = `ELD_LIMIT_1;
            2'd2: size_limit = `ELD_LIMIT_2;
            default: size_limit = `ELD_LIMIT_3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    wire        start_w  = strap_capture | load_start | reload_q;
    wire        over_w   = ee_addr_q > size_limit(eeprom_size_strap);
    wire        got_w    = (state_q == S_READ) && !over_w && ee_rd_valid;
    wire        magic_w  = ee_rd_data == `ELD_MAGIC;
    wire [47:0] mac_w    = {ee_rd_data, mac_q[47:8]};
    wire [31:0] word_w   = {word_q[23:0], ee_rd_data};
    wire        idle_w   = !switch_flag_a && !phy_mgmt_busy_flag;
    wire        fire_w   = reg_wr_req && reg_wr_ack;
    wire        last_b_w = nb_q == 8'h01;
    wire        apb_acc  = psel && penable && clk_en;
    wire        apb_ctrl = paddr == `ELD_APB_CTRL;
    wire        apb_map  = apb_ctrl || paddr == `ELD_APB_STATUS || paddr == `ELD_APB_STRAPS;
    wire        reload_w = apb_acc && pwrite && apb_ctrl && pwdata[0];
    wire [31:0] status_w = {28'h0000000, ee_ok_q, ovf_q, !busy_q, busy_q};
    wire [31:0] rd_mux_w = (paddr == `ELD_APB_STATUS) ? status_w :
                           (paddr == `ELD_APB_STRAPS)  ? straps_q : 32'h0000_0000;

    assign ee_rd_req             = (state_q == S_READ) && !over_w;
    assign ee_rd_addr            = ee_addr_q;
    assign reg_wr_req            = (state_q == S_WRITE) && idle_w;
    assign reg_wr                = wr_q;
    assign eeprom_ctrl_busy_flag = busy_q;
    assign device_ready          = !busy_q;
    assign loader_overflow       = ovf_q;
    assign strap_cfg             = straps_q;
    assign pready                = clk_en;
    assign pslverr               = psel && penable && !apb_map;
    assign prdata                = prdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB read data latched in setup, zero wait states
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
        end else if (clk_en && psel && !penable) begin
            prdata_q <= rd_mux_w;
        end
    end

    // Reload request: a new request beats the consume in the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reload_q <= 1'b0;
        end else if (clk_en) begin
            if (reload_w && state_q == S_IDLE) begin
                reload_q <= 1'b1;
            end else if (state_q == S_IDLE) begin
                reload_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Loader sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q    <= S_IDLE;
            phase_q    <= PH_VALID;
            wk_q       <= WK_SYNC;
            wr_q       <= '0;
            straps_q   <= `ELD_STRAP_RST;
            mac_q      <= '0;
            word_q     <= '0;
            ee_addr_q  <= '0;
            nb_q       <= '0;
            cnt_q      <= '0;
            dw_addr_q  <= '0;
            sync_idx_q <= '0;
            step_q     <= '0;
            busy_q     <= 1'b0;
            ovf_q      <= 1'b0;
            ee_ok_q    <= 1'b0;
            sflag_ok_q <= 1'b0;
        end else if (clk_en) begin
            unique case (state_q)
                S_IDLE: begin
                    if (start_w) begin
                        if (strap_capture) begin
                            straps_q <= hw_straps;
                        end
                        busy_q    <= 1'b1;
                        ovf_q     <= 1'b0;
                        ee_addr_q <= '0;
                        phase_q   <= PH_VALID;
                        state_q   <= S_READ;
                    end
                end
                S_READ: begin
                    if (over_w) begin
                        ovf_q   <= 1'b1;
                        state_q <= S_DONE;
                    end else if (ee_rd_valid) begin
                        ee_addr_q <= ee_addr_q + 16'h0001;
                        unique case (phase_q)
                            PH_VALID: begin
                                ee_ok_q    <= magic_w;
                                step_q     <= '0;
                                sync_idx_q <= '0;
                                if (magic_w) begin
                                    phase_q <= PH_MAC;
                                end else begin
                                    state_q <= S_SYNC;
                                end
                            end
                            PH_MAC: begin
                                mac_q  <= mac_w;
                                step_q <= step_q + 3'd1;
                                if (step_q == 3'd5) begin
                                    wr_q    <= '{`ELD_MAC_LO, mac_w[31:0]};
                                    wk_q    <= WK_MAC_LO;
                                    state_q <= S_WRITE;
                                end
                            end
                            PH_SFLAG: begin
                                sflag_ok_q <= magic_w;
                                step_q     <= '0;
                                phase_q    <= PH_STRAP;
                            end
                            PH_STRAP: begin
                                if (sflag_ok_q) begin
                                    straps_q[step_q[1:0]*8 +: 8] <= ee_rd_data;
                                end
                                step_q <= step_q + 3'd1;
                                if (step_q == 3'd3) begin
                                    sync_idx_q <= '0;
                                    state_q    <= S_SYNC;
                                end
                            end
                            PH_BFLAG: begin
                                if (magic_w) begin
                                    phase_q <= PH_NBURST;
                                end else begin
                                    state_q <= S_DONE;
                                end
                            end
                            PH_NBURST: begin
                                nb_q <= ee_rd_data;
                                if (ee_rd_data == 8'h00) begin
                                    state_q <= S_DONE;
                                end else begin
                                    phase_q <= PH_BHI;
                                end
                            end
                            PH_BHI: begin
                                dw_addr_q <= ee_rd_data;
                                phase_q   <= PH_BLO;
                            end
                            PH_BLO: begin
                                cnt_q  <= ee_rd_data;
                                step_q <= '0;
                                if (ee_rd_data != 8'h00) begin
                                    phase_q <= PH_DATA;
                                end else if (last_b_w) begin
                                    state_q <= S_DONE;
                                end else begin
                                    nb_q    <= nb_q - 8'h01;
                                    phase_q <= PH_BHI;
                                end
                            end
                            PH_DATA: begin
                                word_q <= word_w;
                                step_q <= step_q + 3'd1;
                                if (step_q == 3'd3) begin
                                    wr_q    <= '{{dw_addr_q, 2'b00}, word_w};
                                    wk_q    <= WK_BURST;
                                    state_q <= S_WRITE;
                                end
                            end
                            default: state_q <= S_DONE;
                        endcase
                    end
                end
                S_SYNC: begin
                    wr_q    <= sync_item(sync_idx_q, straps_q);
                    wk_q    <= WK_SYNC;
                    state_q <= S_WRITE;
                end
                S_WRITE: begin
                    if (fire_w) begin
                        unique case (wk_q)
                            WK_MAC_LO: begin
                                wr_q <= '{`ELD_MAC_HI, {16'h0000, mac_q[47:32]}};
                                wk_q <= WK_MAC_HI;
                            end
                            WK_MAC_HI: begin
                                phase_q <= PH_SFLAG;
                                state_q <= S_READ;
                            end
                            WK_SYNC: begin
                                if (sync_idx_q != `ELD_SYNC_LAST) begin
                                    sync_idx_q <= sync_idx_q + 4'h1;
                                    state_q    <= S_SYNC;
                                end else if (ee_ok_q) begin
                                    phase_q <= PH_BFLAG;
                                    state_q <= S_READ;
                                end else begin
                                    state_q <= S_DONE;
                                end
                            end
                            WK_BURST: begin
                                dw_addr_q <= dw_addr_q + 8'h01;
                                step_q    <= '0;
                                state_q   <= S_READ;
                                if (cnt_q != 8'h01) begin
                                    cnt_q <= cnt_q - 8'h01;
                                end else if (last_b_w) begin
                                    state_q <= S_DONE;
                                end else begin
                                    nb_q    <= nb_q - 8'h01;
                                    phase_q <= PH_BHI;
                                end
                            end
                        endcase
                    end
                end
                S_DONE: begin
                    busy_q  <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    start_busy_a: assert property (state_q == S_IDLE && start_w && clk_en
        |=> eeprom_ctrl_busy_flag && !device_ready)
        else $error("busy not raised at loader start");
    bad_valid_a: assert property (got_w && phase_q == PH_VALID && !magic_w && clk_en
        |=> state_q == S_SYNC ##1 reg_wr.addr == `ELD_P1_ADV)
        else $error("bad valid byte did not start sync");
    mac_low_a: assert property (reg_wr_req && wk_q == WK_MAC_LO
        |-> reg_wr.addr == `ELD_MAC_LO)
        else $error("mac low write at wrong address");
    strap_keep_a: assert property (got_w && phase_q == PH_STRAP && !sflag_ok_q && clk_en
        |=> $stable(straps_q))
        else $error("discarded strap byte changed straps");
    port_restart_a: assert property (reg_wr_req && reg_wr.addr == `ELD_P1_BASIC
        |-> reg_wr.data[`ELD_B_RESTART])
        else $error("port basic control lacks restart");
    vphy_restart_a: assert property (reg_wr_req && reg_wr.addr == `ELD_VP_BASIC
        |-> reg_wr.data[`ELD_B_RESTART] && reg_wr.data[`ELD_B_ANEN])
        else $error("virtual basic control lacks restart");
    word_order_a: assert property (got_w && phase_q == PH_DATA && step_q == 3'd3 && clk_en
        |=> reg_wr.data[7:0] == $past(ee_rd_data) && reg_wr.data[15:8] == $past(word_q[7:0]))
        else $error("burst word byte order wrong");
    burst_addr_a: assert property (reg_wr_req && wk_q == WK_BURST
        |-> reg_wr.addr == {dw_addr_q, 2'b00})
        else $error("burst write address wrong");
    wr_idle_a: assert property (reg_wr_req
        |-> !switch_flag_a && !phy_mgmt_busy_flag)
        else $error("write issued while interface busy");
    overflow_stop_a: assert property (state_q == S_READ && over_w && clk_en
        |-> !ee_rd_req ##1 loader_overflow ##1 !eeprom_ctrl_busy_flag)
        else $error("overflow not flagged");
    done_clear_a: assert property (state_q == S_DONE && clk_en
        |=> !eeprom_ctrl_busy_flag && state_q == S_IDLE)
        else $error("busy not cleared at finish");
    rd_hold_a: assert property (ee_rd_req && !ee_rd_valid
        |=> $stable(ee_rd_addr))
        else $error("read address moved before data");

    invalid_c: cover property (got_w && phase_q == PH_VALID && !magic_w);
    strap_c:   cover property (got_w && phase_q == PH_STRAP && sflag_ok_q);
    burst_c:   cover property (fire_w && wk_q == WK_BURST);
    ovf_c:     cover property (state_q == S_READ && over_w);
endmodule

/* File: eld_pkg.sv */
package eld_pkg;
    typedef enum logic [2:0] {S_IDLE, S_READ, S_SYNC, S_WRITE, S_DONE} eld_state_type;
    typedef enum logic [3:0] {PH_VALID, PH_MAC, PH_SFLAG, PH_STRAP, PH_BFLAG,
                              PH_NBURST, PH_BHI, PH_BLO, PH_DATA} eld_phase_type;
    typedef enum logic [1:0] {WK_MAC_LO, WK_MAC_HI, WK_SYNC, WK_BURST} eld_wkind_type;
    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] data;
    } eld_wr_type;
endpackage

/* File: tb_eeprom_strap_and_register_loader.sv */
`timescale 1ns/1ps
`include "eld_cfg.svh"
module tb_eeprom_strap_and_register_loader;
    import eld_pkg::*;
    logic        clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, hw_straps = 32'h0, strap_cfg;
    logic        pready, pslverr, er, strap_capture = 1'b0, load_start = 1'b0;
    logic        ee_rd_req, ee_rd_valid, reg_wr_req, reg_wr_ack = 1'b0;
    logic        switch_flag_a = 1'b0, phy_mgmt_busy_flag = 1'b0;
    logic        eeprom_ctrl_busy_flag, device_ready, loader_overflow;
    logic [1:0]  eeprom_size_strap = 2'h1;
    logic [15:0] ee_rd_addr;
    logic [7:0]  ee_rd_data;
    eld_wr_type  reg_wr;
    eld_wr_type  wq[$];
    int          seed = 42064, num_errors = 0, samples_checked = 0, ea = 0;
    localparam logic [9:0] SA [15] = '{`ELD_P1_ADV, `ELD_P1_MODES, `ELD_P1_BASIC,
        `ELD_P2_ADV, `ELD_P2_MODES, `ELD_P2_BASIC, `ELD_PHY_MGMT_ACCESS_REG, `ELD_PMI_DATA,
        `ELD_VP_ADV, `ELD_VP_SPECIAL, `ELD_VP_BASIC, `ELD_LED_CONFIG_REG, `ELD_MFC0,
        `ELD_MFC1, `ELD_MFC2};
    always #20 clk_sys = ~clk_sys;
    eld_loader dut (.clk_sys, .srst, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .strap_capture, .load_start, .hw_straps,
        .eeprom_size_strap, .ee_rd_req, .ee_rd_addr, .ee_rd_valid, .ee_rd_data,
        .reg_wr_req, .reg_wr, .reg_wr_ack, .switch_flag_a, .phy_mgmt_busy_flag,
        .eeprom_ctrl_busy_flag, .device_ready, .loader_overflow, .strap_cfg);
    eld_ee_model ee (.clk_sys, .ee_rd_req, .ee_rd_addr, .ee_rd_valid, .ee_rd_data);
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Sink stalls at random so writes must wait on both busy flags
    always @(posedge clk_sys) begin
        if (!srst) begin
            chk(32'(device_ready ^ eeprom_ctrl_busy_flag), 1, "ready");
            if (reg_wr_req && reg_wr_ack) begin
                chk(32'(switch_flag_a | phy_mgmt_busy_flag), 0, "wr busy");
                wq.push_back(reg_wr);
            end
            if (ee_rd_req && ee_rd_valid) begin
                chk(32'(ee_rd_addr), 32'(ea), "rd order");
                ea <= ea + 1;
            end
        end
        reg_wr_ack <= 1'($random(seed));
        switch_flag_a <= ($random(seed) % 3) == 0;
        phy_mgmt_busy_flag <= ($random(seed) % 3) == 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_busy(input logic v, input int lim);
        for (int n = 0; n < lim && eeprom_ctrl_busy_flag !== v; n++)
            @(posedge clk_sys);
        chk(32'(eeprom_ctrl_busy_flag), 32'(v), "busy level");
    endtask
    task run(input int how);
        wq.delete();
        ea = 0;
        if (how == 2)
            apb(1'b1, `ELD_APB_CTRL, 32'h1);
        else begin
            @(posedge clk_sys);
            strap_capture <= (how == 0);
            load_start <= (how == 1);
            @(posedge clk_sys);
            strap_capture <= 1'b0;
            load_start <= 1'b0;
        end
        wait_busy(1'b1, 8);
        wait_busy(1'b0, 20000);
    endtask
    task chk_sync(input int b);
        logic [31:0] s;
        s = strap_cfg;
        for (int i = 0; i < 15; i++)
            chk(32'(wq[b+i].addr), 32'(SA[i]), "sync addr");
        chk(32'(wq[b+2].data[9] & wq[b+5].data[9]), 1, "phy restart");
        chk(32'(wq[b+10].data[9]), 1, "vphy restart");
        chk(wq[b+6].data | wq[b+7].data, 0, "mgmt default");
        chk(32'(wq[b+11].data[9:0]), 32'({s[31:30], 2'b0, s[29:24]}), "led");
        chk(32'({wq[b+12].data[2:0], wq[b+13].data[2:0], wq[b+14].data[2:0]}),
            32'({s[21:19], s[7:5], s[15:13]}), "flowctl");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 256; i++)
            ee.mem[i] = 8'($random(seed));
        hw_straps <= $random(seed);
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        ee.mem[0] = 8'h00;
        run(0);
        chk(strap_cfg, hw_straps, "pin straps");
        chk(wq.size(), 15, "blank count");
        chk_sync(0);
        $display("test blank image done");
        ee.mem[0] = 8'hA5;
        ee.mem[7] = 8'hA5;
        ee.mem[12] = 8'hA5;
        ee.mem[13] = 8'h02;
        ee.mem[14] = 8'h10;
        ee.mem[15] = 8'h02;
        ee.mem[24] = 8'h33;
        ee.mem[25] = 8'h00;
        eeprom_size_strap <= 2'h3;
        run(2);
        chk(wq.size(), 19, "full count");
        chk(wq[0].data, {ee.mem[4], ee.mem[3], ee.mem[2], ee.mem[1]}, "mac lo");
        chk(wq[1].data, {16'h0, ee.mem[6], ee.mem[5]}, "mac hi");
        chk(strap_cfg, {ee.mem[11], ee.mem[10], ee.mem[9], ee.mem[8]}, "soft");
        chk_sync(2);
        for (int k = 0; k < 2; k++) begin
            chk(32'(wq[17+k].addr), 32'h40 + 4 * k, "burst addr");
            chk(wq[17+k].data, {ee.mem[16+4*k], ee.mem[17+4*k], ee.mem[18+4*k],
                ee.mem[19+4*k]}, "burst data");
        end
        apb(1'b0, `ELD_APB_STATUS, 32'h0);
        chk(rd, 32'hA, "status");
        $display("test full image done");
        ee.mem[7] = 8'h5A;
        ee.mem[12] = 8'h00;
        hw_straps <= strap_cfg;
        eeprom_size_strap <= 2'h2;
        run(1);
        chk(strap_cfg, hw_straps, "kept straps");
        chk(wq.size(), 17, "no burst");
        chk_sync(2);
        $display("test bad flags done");
        eeprom_size_strap <= 2'h0;
        ee.mem[12] = 8'hA5;
        ee.mem[13] = 8'h01;
        ee.mem[14] = 8'h20;
        ee.mem[15] = 8'h28;
        run(0);
        chk(32'(loader_overflow), 1, "overflow");
        chk(wq.size(), 45, "stop count");
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped");
        apb(1'b0, `ELD_APB_STRAPS, 32'h0);
        chk(rd, strap_cfg, "strap read");
        $display("test overflow done");
        end_of_test;
    end
    initial begin
        #(40 * 60000);
        num_errors++;
        end_of_test;
    end
endmodule
